// [hw/pwm_fault_protection.sv]
// Operation
// - Per-input clearing mode: 0 manual, 1 automatic.
// - Even fault_control bits enable fault interrupts.
// - Protection runs when enabled, irrespective interrupt enable.
// - Detected fault kills exactly its mapped outputs.
// - Input enable bit includes input in protection.
// - Write-protect freezes enable, qualify, map registers.
// - Qualified rising edge sets even-position flag.
// - Writing one clears flag; zero ignored.
// - Faults latch even with generators disabled.
// - Clearing flag withdraws its pending interrupt.
// - First sample after two, then every four.
// - Codes select 1, 5, 10, 15 samples.
// - Single-sample mode kills outputs through unclocked path.
// - Six four-bit map groups, one per output.
// - Software-control enable selects software drive bit.
// - Complementary software-driven odd output is its drive bit AND NOT even partner's.
//
// The implementer's own choice: the APB slave port.
module pwm_fault_protection
  import pwm_fault_pkg::*;
(
  // Clock and reset.
  input  wire logic                 I_CLK,
  input  wire logic                 I_ARST_N,
  // APB slave.
  input  wire logic [ADDR_W-1:0]    I_PADDR,
  input  wire logic                 I_PSEL,
  input  wire logic                 I_PENABLE,
  input  wire logic                 I_PWRITE,
  input  wire logic [DATA_W-1:0]    I_PWDATA,
  output logic      [DATA_W-1:0]    O_PRDATA,
  output logic                      O_PREADY,
  output logic                      O_PSLVERR,
  // Fault pins and generator outputs.
  input  wire logic [NUM_FAULT-1:0] I_FAULT,
  input  wire logic [NUM_OUT-1:0]   I_PWM_GEN,
  // Protected outputs and interrupt.
  output logic      [NUM_OUT-1:0]   O_PWM,
  output logic      [NUM_OUT-1:0]   O_FAST_DISABLE,
  output logic                      O_IRQ
);

  // Bus request gathered from the pins.
  apb_req_t req;
  assign req = '{addr: I_PADDR, write: I_PWRITE, wdata: I_PWDATA,
                 sel: I_PSEL, enable: I_PENABLE};

  // Software registers.
  logic [7:0]  fctl_q,  fctl_d;   // fault_control.
  logic [7:0]  fen_q,   fen_d;    // fault_input_enable.
  logic [7:0]  qualify_count_q,  qualify_count_d;   // fault_qualify_samples.
  logic [23:0] dmap_q,  dmap_d;   // fault_disable_map, six groups.
  logic [7:0]  swctl_q, swctl_d;  // software_drive_control.
  logic [7:0]  swdrv_q, swdrv_d;  // Software drive bits.
  logic [7:0]  cfg_q,   cfg_d;    // Write protect and pairing mode.

  // Bus response flops.
  logic              ready_q, ready_d;
  logic              err_q,   err_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  // Fault pin synchronisers; only sync2 is read by logic.
  logic [NUM_FAULT-1:0] sync1_q;
  logic [NUM_FAULT-1:0] sync2_q;

  // Per-input qualification state.
  logic [3:0]           cnt_q   [NUM_FAULT];
  logic [3:0]           cnt_d   [NUM_FAULT];
  logic [1:0]           ph_q    [NUM_FAULT];
  logic [1:0]           ph_d    [NUM_FAULT];
  logic [NUM_FAULT-1:0] done_q,  done_d;   // Edge already qualified.
  logic [NUM_FAULT-1:0] flag_q,  flag_d;   // Sticky fault flags.
  logic [NUM_FAULT-1:0] act_q,   act_d;    // Fault holding outputs off.
  logic [NUM_FAULT-1:0] det;               // Qualification this cycle.
  logic [4:0]           run_q,   run_d;    // Check helper: input 1 run.

  // Output flops.
  logic [NUM_OUT-1:0] pwm_q, pwm_d;
  logic               irq_q, irq_d;

  // Decoded views of the registers.
  logic [NUM_FAULT-1:0] input_on;
  logic [NUM_FAULT-1:0] irq_en;
  logic [NUM_FAULT-1:0] auto_clr;
  logic [NUM_FAULT-1:0] single_smp;
  logic [NUM_FAULT-1:0] clr_req;
  logic                 wr_en;
  logic [ADDR_W-1:0]    idx;

  // Field extraction; bit positions come from the package.
  always_comb begin
    for (int i = 0; i < NUM_FAULT; i++) begin
      input_on[i]   = fen_q[2*i+POS_INPUT_ON];
      irq_en[i]     = fctl_q[2*i+POS_IRQ_EN];
      auto_clr[i]   = fctl_q[2*i+POS_CLR_MODE];
      single_smp[i] = (qualify_count_q[2*i+:2] == 2'h0);
    end
  end

  // A write lands only on the completing access edge.
  assign wr_en = req.sel && req.enable && ready_q && req.write;
  assign idx   = {2'h0, req.addr[ADDR_W-1:2]};

  // Flags that software is clearing with a written one this cycle.
  always_comb begin
    for (int i = 0; i < NUM_FAULT; i++) begin
      clr_req[i] = wr_en && (req.addr[1:0] == 2'h0) && (idx == IDX_FLAGS)
                   && req.wdata[2*i+POS_FLAG];
    end
  end

  // Register next state. Protected registers ignore writes once the
  // write-protect bit is up; the bit itself only falls at reset, so a
  // runaway program cannot reopen the enable, qualify and map registers.
  always_comb begin
    fctl_d  = fctl_q;
    fen_d   = fen_q;
    qualify_count_d  = qualify_count_q;
    dmap_d  = dmap_q;
    swctl_d = swctl_q;
    swdrv_d = swdrv_q;
    cfg_d   = cfg_q;
    if (wr_en && req.addr[1:0] == 2'h0) begin
      unique case (idx)
        IDX_FAULT_CTL: fctl_d = req.wdata[7:0];
        IDX_FAULT_EN: begin
          if (!cfg_q[POS_WPROT]) fen_d = req.wdata[7:0];
        end
        IDX_QUALIFY: begin
          if (!cfg_q[POS_WPROT]) qualify_count_d = req.wdata[7:0];
        end
        IDX_DMAP01: begin
          if (!cfg_q[POS_WPROT]) dmap_d[7:0] = req.wdata[7:0];
        end
        IDX_DMAP23: begin
          if (!cfg_q[POS_WPROT]) dmap_d[15:8] = req.wdata[7:0];
        end
        IDX_DMAP45: begin
          if (!cfg_q[POS_WPROT]) dmap_d[23:16] = req.wdata[7:0];
        end
        IDX_SW_CTL:   swctl_d = {2'h0, req.wdata[5:0]};
        IDX_SW_DRIVE: swdrv_d = {2'h0, req.wdata[5:0]};
        IDX_CONFIG: begin
          cfg_d[POS_WPROT] = cfg_q[POS_WPROT] | req.wdata[POS_WPROT];
          cfg_d[POS_COMP]  = req.wdata[POS_COMP];
        end
        default: begin
          // Flags and unmapped indices store nothing here.
        end
      endcase
    end
  end

  // Bus answer: ready rises for the access phase, so every transfer
  // takes exactly one setup and one access cycle.
  always_comb begin
    ready_d = req.sel && !req.enable;
    err_d   = 1'b0;
    rdata_d = '0;
    if (req.sel && !req.enable) begin
      if (req.addr[1:0] != 2'h0) begin
        err_d = 1'b1;
      end else begin
        unique case (idx)
          IDX_FAULT_CTL: rdata_d[7:0] = fctl_q;
          IDX_FAULT_EN:  rdata_d[7:0] = fen_q;
          IDX_FLAGS: begin
            for (int i = 0; i < NUM_FAULT; i++) begin
              rdata_d[2*i+POS_FLAG] = flag_q[i];
            end
          end
          IDX_QUALIFY:  rdata_d[7:0] = qualify_count_q;
          IDX_DMAP01:   rdata_d[7:0] = dmap_q[7:0];
          IDX_DMAP23:   rdata_d[7:0] = dmap_q[15:8];
          IDX_DMAP45:   rdata_d[7:0] = dmap_q[23:16];
          IDX_SW_CTL:   rdata_d[7:0] = swctl_q;
          IDX_SW_DRIVE: rdata_d[7:0] = swdrv_q;
          IDX_CONFIG:   rdata_d[7:0] = cfg_q;
          default:      err_d = 1'b1;
        endcase
      end
    end
  end

  // Register and bus flops.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      fctl_q  <= RST_BYTE;
      fen_q   <= RST_BYTE;
      qualify_count_q  <= RST_BYTE;
      dmap_q  <= RST_DMAP;
      swctl_q <= RST_BYTE;
      swdrv_q <= RST_BYTE;
      cfg_q   <= RST_BYTE;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      fctl_q  <= fctl_d;
      fen_q   <= fen_d;
      qualify_count_q  <= qualify_count_d;
      dmap_q  <= dmap_d;
      swctl_q <= swctl_d;
      swdrv_q <= swdrv_d;
      cfg_q   <= cfg_d;
      ready_q <= ready_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
    end
  end

  // Two-flop synchroniser; its latency is the two-cycle first sample.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= I_FAULT;
      sync2_q <= sync1_q;
    end
  end

  // Qualification: a sample every four cycles while the synchronised
  // input stays high; a low sample restarts the run, so only
  // consecutive samples count. The done bit waits for the next edge.
  always_comb begin
    det = '0;
    // Check helper: cycles input 1 has stayed high while enabled.
    run_d = 5'h00;
    if (sync2_q[1] && input_on[1]) run_d = run_q + {4'h0, run_q != 5'h1F};
    for (int i = 0; i < NUM_FAULT; i++) begin
      cnt_d[i]  = cnt_q[i];
      ph_d[i]   = ph_q[i];
      done_d[i] = done_q[i];
      if (!sync2_q[i] || !input_on[i]) begin
        cnt_d[i]  = 4'h0;
        ph_d[i]   = 2'h0;
        done_d[i] = 1'b0;
      end else if (!done_q[i]) begin
        ph_d[i] = ph_q[i] + 2'h1;
        if (ph_q[i] == 2'h0) begin
          if (cnt_q[i] + 4'h1 >= qual_need(qualify_count_q[2*i+:2])) begin
            det[i]    = 1'b1;
            done_d[i] = 1'b1;
            cnt_d[i]  = 4'h0;
          end else begin
            cnt_d[i] = cnt_q[i] + 4'h1;
          end
        end
      end
    end
  end

  // Flags and output holds. A detection in the clearing cycle wins.
  // Nothing here looks at the generators, so faults latch even while
  // they are stopped.
  always_comb begin
    for (int i = 0; i < NUM_FAULT; i++) begin
      flag_d[i] = (flag_q[i] && !clr_req[i]) || det[i];
      act_d[i]  = act_q[i];
      if (det[i]) begin
        act_d[i] = 1'b1;
      end else if (!input_on[i]) begin
        act_d[i] = 1'b0;
      end else if (auto_clr[i]) begin
        if (!sync2_q[i]) act_d[i] = 1'b0;
      end else begin
        if (!flag_d[i] && !sync2_q[i]) act_d[i] = 1'b0;
      end
    end
  end

  // Qualification flops.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int i = 0; i < NUM_FAULT; i++) begin
        cnt_q[i] <= 4'h0;
        ph_q[i]  <= 2'h0;
      end
      done_q <= '0;
      flag_q <= '0;
      act_q  <= '0;
      run_q  <= 5'h00;
    end else begin
      for (int i = 0; i < NUM_FAULT; i++) begin
        cnt_q[i] <= cnt_d[i];
        ph_q[i]  <= ph_d[i];
      end
      done_q <= done_d;
      flag_q <= flag_d;
      act_q  <= act_d;
      run_q  <= run_d;
    end
  end

  // Output selection: software drive overrides the generator, and any
  // mapped fault forces the output inactive on top of both.
  always_comb begin
    for (int o = 0; o < NUM_OUT; o++) begin
      if (swctl_q[o]) begin
        if (cfg_q[POS_COMP] && (o % 2 == 1)) begin
          pwm_d[o] = swdrv_q[o] && !swdrv_q[o^1];
        end else begin
          pwm_d[o] = swdrv_q[o];
        end
      end else begin
        pwm_d[o] = I_PWM_GEN[o];
      end
      if (|(dmap_q[MAP_W*o+:MAP_W] & act_q)) begin
        pwm_d[o] = 1'b0;
      end
    end
    irq_d = |(flag_d & irq_en);
  end

  // Output flops.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pwm_q <= '0;
      irq_q <= 1'b0;
    end else begin
      pwm_q <= pwm_d;
      irq_q <= irq_d;
    end
  end

  // Unclocked kill for single-sample inputs. It is the one output not
  // from a flop: it must act before the synchroniser has caught up.
  always_comb begin
    for (int o = 0; o < NUM_OUT; o++) begin
      O_FAST_DISABLE[o] = |(dmap_q[MAP_W*o+:MAP_W] & I_FAULT
                            & input_on & single_smp);
    end
  end

  assign O_PWM     = pwm_q;
  assign O_IRQ     = irq_q;
  assign O_PRDATA  = rdata_q;
  assign O_PREADY  = ready_q;
  assign O_PSLVERR = err_q;

  // Checks on the design's own behaviour.
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  chk_flag_w1c_clear: assert property (
    (clr_req[0] && !det[0]) |=> !flag_q[0])
    else $error("Flag 0 survived a write-one clear.");

  chk_irq_withdraw: assert property (
    (flag_q == 4'h1 && clr_req[0] && det == 4'h0) |=> !O_IRQ)
    else $error("Interrupt stayed after its flag was cleared.");

  chk_disabled_input_quiet: assert property (
    !input_on[1] |-> !det[1])
    else $error("Disabled input produced a detection.");

  chk_wprot_lock: assert property (
    (cfg_q[POS_WPROT] && wr_en) |=> $stable(fen_q) && $stable(qualify_count_q)
    && $stable(dmap_q))
    else $error("Protected register changed under write protect.");

  chk_single_sample_delay: assert property (
    (input_on[0] && single_smp[0] && $rose(sync2_q[0]) && !done_q[0])
    |=> flag_q[0])
    else $error("Single-sample fault did not flag next cycle.");

  chk_five_sample_run: assert property (
    (det[1] && input_on[1] && qualify_count_q[3:2] == 2'h1)
    |-> run_q == 5'(SMP_PERIOD_CYC * (QUAL_N1 - 4'h1)))
    else $error("Five-sample fault qualified at the wrong cycle.");

  chk_fault_kills_out: assert property (
    (act_q[0] && dmap_q[0]) |=> !O_PWM[0])
    else $error("Mapped fault did not force output 0 inactive.");

  chk_sw_drive_out: assert property (
    (swctl_q[2] && act_q == 4'h0 && !cfg_q[POS_COMP]) |=>
    O_PWM[2] == $past(swdrv_q[2]))
    else $error("Output 2 did not follow its software drive bit.");

  chk_comp_odd_out: assert property (
    (swctl_q[3] && cfg_q[POS_COMP] && act_q == 4'h0 && swdrv_q[3:2] == 2'h3)
    |=> !O_PWM[3])
    else $error("Odd output did not complement its partner.");

  chk_auto_release: assert property (
    (auto_clr[3] && input_on[3] && !sync2_q[3] && !det[3]) |=> !act_q[3])
    else $error("Automatic clearing did not release output hold.");

  chk_fast_kill: assert property (
    (single_smp[0] && input_on[0] && I_FAULT[0] && dmap_q[0])
    |-> O_FAST_DISABLE[0])
    else $error("Unclocked kill missing in single-sample mode.");

endmodule : pwm_fault_protection

// [hw/pwm_fault_pkg.sv]
package pwm_fault_pkg;

  // Sizes of the fault section.
  localparam int NUM_FAULT = 4;
  localparam int NUM_OUT   = 6;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [ADDR_W-1:0] IDX_FAULT_CTL = 8'h04;
  localparam logic [ADDR_W-1:0] IDX_FAULT_EN  = 8'h05;
  localparam logic [ADDR_W-1:0] IDX_FLAGS     = 8'h06;
  localparam logic [ADDR_W-1:0] IDX_QUALIFY   = 8'h07;
  localparam logic [ADDR_W-1:0] IDX_DMAP01    = 8'h08;
  localparam logic [ADDR_W-1:0] IDX_DMAP23    = 8'h09;
  localparam logic [ADDR_W-1:0] IDX_DMAP45    = 8'h0A;
  localparam logic [ADDR_W-1:0] IDX_SW_CTL    = 8'h0C;
  localparam logic [ADDR_W-1:0] IDX_SW_DRIVE  = 8'h0D;
  localparam logic [ADDR_W-1:0] IDX_CONFIG    = 8'h10;

  // Field positions.
  localparam int POS_IRQ_EN   = 0;  // Bit 2x of fault_control.
  localparam int POS_CLR_MODE = 1;  // Bit 2x+1 of fault_control.
  localparam int POS_FLAG     = 0;  // Bit 2x of fault_flags.
  localparam int POS_INPUT_ON = 0;  // Bit 2x of fault_input_enable.
  localparam int POS_WPROT    = 0;  // Write-protect bit of config.
  localparam int POS_COMP     = 1;  // Complementary pairing bit.
  localparam int MAP_W        = 4;  // Disable-map bits per output.

  // Reset values.
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [23:0] RST_DMAP = 24'h000000;

  // Sampling timing in bus cycles.
  localparam int SMP_FIRST_CYC  = 2;
  localparam int SMP_PERIOD_CYC = 4;
  localparam logic [3:0] QUAL_N0 = 4'h1;
  localparam logic [3:0] QUAL_N1 = 4'h5;
  localparam logic [3:0] QUAL_N2 = 4'hA;
  localparam logic [3:0] QUAL_N3 = 4'hF;

  // One APB request as seen by the slave.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic [DATA_W-1:0] wdata;
    logic              sel;
    logic              enable;
  } apb_req_t;

  // Consecutive samples needed for a qualifying-count code.
  function automatic logic [3:0] qual_need(input logic [1:0] code);
    unique case (code)
      2'h0: qual_need = QUAL_N0;
      2'h1: qual_need = QUAL_N1;
      2'h2: qual_need = QUAL_N2;
      2'h3: qual_need = QUAL_N3;
    endcase
  endfunction : qual_need

endpackage : pwm_fault_pkg

// [verification/fault_source.sv]
// Model of the external fault detector: it raises one fault pin for a set
// number of cycles, then drives it low again, as a comparator output would.
module fault_source
  import pwm_fault_pkg::*;
(
  // Clock and reset.
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  // Pulse request from the bench.
  input  wire logic                 i_start,
  input  wire logic [1:0]           i_pin,
  input  wire logic [7:0]           i_len,
  // Fault pins towards the block.
  output logic      [NUM_FAULT-1:0] o_fault
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] left_q, left_d;  // Cycles the pin still stays high.
  logic [1:0] pin_q, pin_d;    // Pin that carries the pulse.

  // A new request restarts the count; short pulses model glitches.
  always_comb begin
    left_d = (left_q != 8'h00) ? left_q - 8'h01 : 8'h00;
    pin_d = pin_q;
    if (i_start) begin
      left_d = i_len;
      pin_d = i_pin;
    end
  end

  // State registers.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      left_q <= 8'h00;
      pin_q <= 2'h0;
    end else begin
      left_q <= left_d;
      pin_q <= pin_d;
    end
  end

  // Idle pins are driven low, never left floating.
  always_comb begin
    o_fault = '0;
    o_fault[pin_q] = (left_q != 8'h00);
  end
endmodule : fault_source

// [verification/test_pwm_fault_protection.sv]
module test_pwm_fault_protection
  import pwm_fault_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk = 1'h0, arst_n = 1'h0, start = 1'h0;
  logic              psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata, rd;
  logic              pready, pslverr, irq, er;
  logic [3:0]        fault;
  logic [1:0]        pin = 2'h0;
  logic [7:0]        len = 8'h00;
  logic [5:0]        gen = 6'h3F, pwm, fast;
  int                n_fail = 0, checks_done = 0;

  always #12.5 clk = ~clk;

  pwm_fault_protection i_pwm_fault_protection (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_PADDR(paddr), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_FAULT(fault), .I_PWM_GEN(gen), .O_PWM(pwm),
    .O_FAST_DISABLE(fast), .O_IRQ(irq));

  fault_source i_fault_source (
    .i_clk(clk), .i_arst_n(arst_n), .i_start(start), .i_pin(pin),
    .i_len(len), .o_fault(fault));

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; entered right after a rising edge.
  task automatic apb(input logic wr, input logic [7:0] idx, wd);
    int n;
    n = 0;
    paddr <= {idx[5:0], 2'h0};
    pwrite <= wr;
    pwdata <= {24'h0, wd};
    psel <= 1'h1;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // One idle edge, so a following call never reassigns psel at once.
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, d);
    apb(1'h1, idx, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] idx, exp);
    apb(1'h0, idx, 8'h00);
    chk(nm, rd, {24'h0, exp});
  endtask : rdc

  // Fault pulse; the interrupt must rise exactly need edges after the pin.
  task automatic hit(input logic [1:0] p, input logic [7:0] l,
                     input int need, input logic [5:0] fd, input logic q);
    start <= 1'h1;
    pin <= p;
    len <= l;
    @(posedge clk);
    start <= 1'h0;
    @(posedge clk);
    chk("fast path", fast, fd);
    repeat (need - 1) @(posedge clk);
    chk("irq early", irq, 1'h0);
    @(posedge clk);
    chk("irq", irq, q);
  endtask : hit

  task automatic t_regs();
    logic [7:0] ix [10] = '{IDX_FAULT_CTL, IDX_FAULT_EN, IDX_FLAGS,
      IDX_QUALIFY, IDX_DMAP01, IDX_DMAP23, IDX_DMAP45, IDX_SW_CTL,
      IDX_SW_DRIVE, IDX_CONFIG};
    foreach (ix[i]) begin
      rdc("reset value", ix[i], RST_BYTE);
      chk("no error", er, 1'h0);
    end
    apb(1'h0, 8'h3F, 8'h00);
    chk("unmapped", er, 1'h1);
    wr(IDX_SW_DRIVE, 8'h2D);
    rdc("read back", IDX_SW_DRIVE, 8'h2D);
    $display("test regs done");
  endtask : t_regs

  task automatic t_single();
    wr(IDX_FAULT_CTL, 8'h01);
    wr(IDX_FAULT_EN, 8'h01);
    wr(IDX_DMAP01, 8'h01);
    wr(IDX_DMAP23, 8'h10);
    hit(2'h0, 8'h06, 3, 6'h09, 1'h1);
    @(posedge clk);
    chk("masked", pwm, 6'h36);
    repeat (12) @(posedge clk);
    chk("held", pwm, 6'h36);
    wr(IDX_FLAGS, 8'h00);
    rdc("flag kept", IDX_FLAGS, 8'h01);
    wr(IDX_FLAGS, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 1'h0);
    repeat (2) @(posedge clk);
    chk("released", pwm, 6'h3F);
    gen <= 6'h00;
    hit(2'h0, 8'h06, 3, 6'h09, 1'h1);
    wr(IDX_FLAGS, 8'h01);
    gen <= 6'h3F;
    $display("test single done");
  endtask : t_single

  task automatic t_qual();
    int n [3] = '{5, 10, 15};
    wr(IDX_FAULT_CTL, 8'h04);
    wr(IDX_FAULT_EN, 8'h04);
    wr(IDX_DMAP01, 8'h20);
    for (int k = 0; k < 3; k++) begin
      wr(IDX_QUALIFY, 8'((k + 1) << 2));
      hit(2'h1, 8'(4 * n[k] + 2), 4 * n[k] - 1, 6'h00, 1'h1);
      wr(IDX_FLAGS, 8'h04);
      repeat (8) @(posedge clk);
    end
    // A pulse shorter than five samples must not qualify.
    wr(IDX_QUALIFY, 8'h04);
    hit(2'h1, 8'h0A, 19, 6'h00, 1'h0);
    $display("test qualify done");
  endtask : t_qual

  task automatic t_off();
    wr(IDX_FAULT_CTL, 8'h00);
    wr(IDX_FAULT_EN, 8'h00);
    wr(IDX_QUALIFY, 8'h00);
    wr(IDX_DMAP45, 8'h44);
    hit(2'h2, 8'h06, 3, 6'h00, 1'h0);
    rdc("no flag", IDX_FLAGS, 8'h00);
    wr(IDX_FAULT_EN, 8'h10);
    hit(2'h2, 8'h06, 3, 6'h30, 1'h0);
    @(posedge clk);
    chk("masked", pwm, 6'h0F);
    rdc("flag", IDX_FLAGS, 8'h10);
    wr(IDX_FLAGS, 8'h10);
    $display("test disabled done");
  endtask : t_off

  task automatic t_auto();
    wr(IDX_FAULT_CTL, 8'h80);
    wr(IDX_FAULT_EN, 8'h40);
    wr(IDX_DMAP01, 8'h08);
    hit(2'h3, 8'h06, 3, 6'h01, 1'h0);
    @(posedge clk);
    chk("masked", pwm, 6'h3E);
    repeat (8) @(posedge clk);
    chk("auto release", pwm, 6'h3F);
    rdc("flag kept", IDX_FLAGS, 8'h40);
    wr(IDX_FLAGS, 8'h40);
    $display("test auto done");
  endtask : t_auto

  task automatic t_sw();
    wr(IDX_SW_CTL, 8'h3F);
    repeat (3) @(posedge clk);
    chk("sw drive", pwm, 6'h2D);
    wr(IDX_CONFIG, 8'h02);
    repeat (3) @(posedge clk);
    chk("sw comp", pwm, 6'h25);
    wr(IDX_CONFIG, 8'h00);
    wr(IDX_SW_CTL, 8'h03);
    gen <= 6'h14;
    repeat (3) @(posedge clk);
    chk("sw part", pwm, 6'h15);
    $display("test software done");
  endtask : t_sw

  task automatic t_wprot();
    logic [7:0] ix [5] = '{IDX_FAULT_EN, IDX_QUALIFY, IDX_DMAP01,
      IDX_DMAP23, IDX_DMAP45};
    logic [7:0] v [5] = '{8'h40, 8'h00, 8'h08, 8'h10, 8'h44};
    wr(IDX_CONFIG, 8'h01);
    foreach (ix[i]) begin
      wr(ix[i], 8'hFF);
      rdc("protected", ix[i], v[i]);
    end
    wr(IDX_FAULT_CTL, 8'h55);
    rdc("unprotected", IDX_FAULT_CTL, 8'h55);
    $display("test protect done");
  endtask : t_wprot

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // Reset is held for 20 cycles; setup may follow the first edge after.
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_single();
    t_qual();
    t_off();
    t_auto();
    t_sw();
    t_wprot();
    end_sim();
  end

  // The whole run needs well under 2000 cycles.
  initial begin
    #(25 * 8000);
    n_fail++;
    end_sim();
  end
endmodule : test_pwm_fault_protection
